// ---- tb/npic_core_model.sv ----
// Core model: reports instruction ends to the interrupt controller.
// Assumes the system clock and reset of the controller.
`timescale 1ns/1ps

module npic_core_model (
	input wire logic clk_sys, // System clock
	input wire logic reset_n, // Asynchronous reset
	input wire logic slow, // Four-cycle instructions when high
	output logic instr_done // Instruction ends this cycle
);
	logic [1:0] cyc_reg; // Cycle within the instruction

	// Cycle counter inside a long instruction
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cyc_reg <= 2'h0;
		end else begin
			cyc_reg <= cyc_reg + 2'h1;
		end
	end

	assign instr_done = slow ? (cyc_reg == 2'h3) : 1'b1;
endmodule

// ---- tb/npic_top_assertions.sv ----
// Concurrent checks on the interrupt controller's top-level ports.
// Assumes one clock domain and the constants header beside the design.
`timescale 1ns/1ps
`include "npic_cfg.svh"

module npic_top_checker (
	input wire logic clk_sys, // System clock
	input wire logic reset_n, // Asynchronous reset
	input wire logic [2:0] addr, // Register address
	input wire logic rd_en, // Read strobe
	input wire logic [7:0] rd_data, // Read data
	input wire logic instr_done, // Instruction end
	input wire npic_pkg::npic_cmd_t cpu_cmd, // Level-changing opcode
	input wire npic_pkg::npic_svc_t svc, // Service entry
	input wire logic cur_level_hi, // Current level high bit
	input wire logic cur_level_lo // Current level low bit
);
	// Rank of the current code: 10->0, 01->1, 00->2, 11->3
	wire [1:0] cur_rank = {cur_level_hi ~^ cur_level_lo, cur_level_lo};
	wire [1:0] cur_code = {cur_level_hi, cur_level_lo};

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	chk_entry_at_end: assert property (svc.valid |-> $past(instr_done))
		else $error("entry without instruction end");
	chk_nmi_level3: assert property (svc.valid && svc.vector >= 4'hd |-> cur_code == 2'h3)
		else $error("non-maskable entry did not load level 3");
	chk_stack_flag: assert property (svc.valid |-> svc.stack == (svc.vector != 4'he))
		else $error("stack flag wrong for entry");
	chk_nest_strict: assert property (svc.valid && svc.vector < 4'hd |-> cur_rank > $past(cur_rank))
		else $error("maskable entry not above previous level");
	chk_level_cause: assert property ($changed(cur_level_hi) || $changed(cur_level_lo)
		|-> svc.valid || $past(cpu_cmd.valid))
		else $error("level changed without entry or instruction");
	chk_enable_code: assert property (cpu_cmd.valid && cpu_cmd.op == npic_pkg::NPIC_OP_ENABLE
		|=> svc.valid || cur_code == `NPIC_CODE_L0)
		else $error("enable did not load level 0");
	chk_disable_code: assert property (cpu_cmd.valid && cpu_cmd.op == npic_pkg::NPIC_OP_DISABLE
		|=> svc.valid || cur_code == `NPIC_CODE_L3)
		else $error("disable did not load level 3");
	chk_restore_code: assert property (cpu_cmd.valid && (cpu_cmd.op == npic_pkg::NPIC_OP_RETURN
		|| cpu_cmd.op == npic_pkg::NPIC_OP_POP) |=> svc.valid || cur_code == $past(cpu_cmd.code))
		else $error("return or pop did not restore level");
	chk_top_bits_one: assert property ($past(rd_en) && $past(addr) == `NPIC_OFF_VP3
		|-> rd_data[7:2] == `NPIC_VP3_FIXED)
		else $error("fixed bits of fourth register not one");
	chk_sleep_levels: assert property (cpu_cmd.valid && (cpu_cmd.op == npic_pkg::NPIC_OP_HALT
		|| cpu_cmd.op == npic_pkg::NPIC_OP_WAIT) |=> svc.valid || cur_code == 2'h2)
		else $error("halt or wait did not load level 0");
endmodule

bind npic_top npic_top_checker i_npic_top_checker (.clk_sys(clk_sys), .reset_n(reset_n),
	.addr(addr), .rd_en(rd_en), .rd_data(rd_data), .instr_done(instr_done), .cpu_cmd(cpu_cmd),
	.svc(svc), .cur_level_hi(cur_level_hi), .cur_level_lo(cur_level_lo));

// ---- tb/tb.sv ----
// Self-checking bench of the nested interrupt controller.
// Assumes the core model supplies instruction ends.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
	logic clk_sys, reset_n, wr_en, rd_en, trap_req, instr_done, slow, wake;
	logic cur_level_hi, cur_level_lo; // Current level outputs
	logic [2:0] addr, ext_en;
	logic [7:0] wr_data, rd_data;
	logic [23:0] ext_pin, ext_pin_sel;
	logic [9:0] periph_flag, periph_en, periph_clr;
	npic_pkg::npic_cmd_t cpu_cmd; // Instruction report
	npic_pkg::npic_svc_t svc, last_svc; // Entry and last seen entry
	logic [1:0] last_lvl; // Level loaded by last entry
	int n_svc, n_wake, bad_count, n_checks;

	npic_top i_npic_top (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_pin(ext_pin),
		.ext_pin_sel(ext_pin_sel), .ext_en(ext_en), .periph_flag(periph_flag),
		.periph_en(periph_en), .periph_clr(periph_clr), .trap_req(trap_req),
		.instr_done(instr_done), .cpu_cmd(cpu_cmd), .svc(svc), .cur_level_hi(cur_level_hi),
		.cur_level_lo(cur_level_lo), .wake(wake));
	npic_core_model i_npic_core_model (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow),
		.instr_done(instr_done));

	// Clock, 20 ns period
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Entry and wake monitor, sampled mid-cycle
	always @(negedge clk_sys) begin
		if (reset_n && svc.valid === 1'b1) begin
			n_svc++;
			last_svc = svc;
			last_lvl = {cur_level_hi, cur_level_lo};
		end
		if (reset_n && wake === 1'b1) n_wake++;
	end

	task automatic tally_and_finish();
		if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk_sys);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		@(negedge clk_sys);
		`CHK(rd_data & m, e)
	endtask

	task automatic cmd(input npic_pkg::npic_op_t op, input logic [1:0] c);
		@(posedge clk_sys);
		cpu_cmd <= '{valid: 1'b1, op: op, code: c};
		@(posedge clk_sys);
		cpu_cmd.valid <= 1'b0;
	endtask

	// Clear sequence: flag drops, clear pulse
	task automatic clr(input int b);
		@(posedge clk_sys);
		periph_flag[b] <= 1'b0;
		periph_clr[b] <= 1'b1;
		@(posedge clk_sys);
		periph_clr[b] <= 1'b0;
	endtask

	task automatic idle(input int n);
		int n0;
		n0 = n_svc;
		repeat (n) @(posedge clk_sys);
		`CHK(n_svc, n0)
	endtask

	task automatic take(input logic [3:0] v, input logic [1:0] c, input logic s);
		int n0;
		n0 = n_svc;
		for (int i = 0; i < 30 && n_svc == n0; i++) @(posedge clk_sys);
		`CHK(n_svc, n0 + 1)
		`CHK(last_svc, {1'b1, v, s})
		`CHK(last_lvl, c)
	endtask

	task automatic t_reset();
		repeat (3) @(posedge clk_sys);
		`CHK(n_svc, 1)
		`CHK(last_svc, {1'b1, 4'he, 1'b0})
		for (int a = 0; a < 4; a++) rd(3'(a), 8'hff, 8'hff);
	endtask

	task automatic t_regs();
		wr(3'h0, 8'hcf);
		wr(3'h0, 8'h64);
		rd(3'h0, 8'hff, 8'h44);
		wr(3'h3, 8'h00);
		rd(3'h3, 8'hff, 8'hfc);
		wr(3'h4, 8'h00);
		rd(3'h4, 8'h28, 8'h28);
		wr(3'h0, 8'h41);
	endtask

	// Source 1 at level 2 beats source 0 at level 1
	task automatic t_sw();
		cmd(npic_pkg::NPIC_OP_ENABLE, 2'h0);
		@(posedge clk_sys);
		periph_flag <= periph_flag | 10'h003;
		take(4'h1, 2'h0, 1'b1);
		idle(8);
		rd(3'h5, 8'h03, 8'h03);
		// Raise own field while still pending: re-entry at level 3
		wr(3'h0, 8'h4d);
		take(4'h1, 2'h3, 1'b1);
		wr(3'h0, 8'h41);
		clr(1);
		cmd(npic_pkg::NPIC_OP_RETURN, 2'h2);
		take(4'h0, 2'h1, 1'b1);
		clr(0);
		cmd(npic_pkg::NPIC_OP_RETURN, 2'h2);
	endtask

	// Equal level tie, long instructions, disabled and discarded sources
	task automatic t_hw();
		slow <= 1'b1;
		periph_en <= 10'h3ef;
		@(posedge clk_sys);
		periph_flag <= periph_flag | 10'h01c;
		take(4'h5, 2'h3, 1'b1);
		rd(3'h5, 8'he0, 8'h60);
		clr(2);
		cmd(npic_pkg::NPIC_OP_RETURN, 2'h2);
		take(4'h6, 2'h3, 1'b1);
		clr(3);
		cmd(npic_pkg::NPIC_OP_RETURN, 2'h2);
		idle(12);
		clr(4);
		periph_en <= 10'h3ff;
		// Source 8 pends under level 3, then its clear sequence drops it
		cmd(npic_pkg::NPIC_OP_DISABLE, 2'h0);
		periph_flag[5] <= 1'b1;
		idle(8);
		rd(3'h6, 8'h01, 8'h01);
		clr(5);
		cmd(npic_pkg::NPIC_OP_ENABLE, 2'h0);
		idle(12);
		slow <= 1'b0;
	endtask

	// Trap beats a maskable that pends in the same cycle
	task automatic t_trap();
		cmd(npic_pkg::NPIC_OP_ENABLE, 2'h0);
		@(posedge clk_sys);
		periph_flag[0] <= 1'b1;
		trap_req <= 1'b1;
		@(posedge clk_sys);
		trap_req <= 1'b0;
		take(4'hd, 2'h3, 1'b1);
		idle(8);
		cmd(npic_pkg::NPIC_OP_ENABLE, 2'h0);
		take(4'h0, 2'h1, 1'b1);
		clr(0);
		cmd(npic_pkg::NPIC_OP_RETURN, 2'h2);
	endtask

	// Pin 5 of line 0 ORed with pin 0, edge cleared on entry
	task automatic t_ext();
		ext_pin_sel <= 24'h00_0121;
		ext_en <= 3'h7;
		@(posedge clk_sys);
		ext_pin[5] <= 1'b1;
		take(4'h2, 2'h0, 1'b1);
		cmd(npic_pkg::NPIC_OP_RETURN, 2'h2);
		idle(10);
		ext_pin[5] <= 1'b0;
	endtask

	// Halt: only a wake-capable source ends it and is served first
	task automatic t_halt();
		int w0;
		w0 = n_wake;
		cmd(npic_pkg::NPIC_OP_HALT, 2'h0);
		periph_flag[1] <= 1'b1;
		idle(10);
		rd(3'h7, 8'hff, 8'h02);
		ext_pin[8] <= 1'b1;
		take(4'h3, 2'h1, 1'b1);
		take(4'h1, 2'h0, 1'b1);
		`CHK(n_wake, w0 + 1)
		clr(1);
		ext_pin[8] <= 1'b0;
		cmd(npic_pkg::NPIC_OP_RETURN, 2'h1);
		cmd(npic_pkg::NPIC_OP_RETURN, 2'h2);
	endtask

	// Wait: any source wakes
	task automatic t_wait();
		int w0;
		w0 = n_wake;
		cmd(npic_pkg::NPIC_OP_WAIT, 2'h0);
		repeat (4) @(posedge clk_sys);
		periph_flag[2] <= 1'b1;
		take(4'h5, 2'h3, 1'b1);
		`CHK(n_wake, w0 + 1)
		clr(2);
		cmd(npic_pkg::NPIC_OP_POP, 2'h2);
	endtask

	// Watchdog against a hang
	initial begin
		repeat (4000) @(posedge clk_sys);
		bad_count++;
		tally_and_finish();
	end

	initial begin
		reset_n = 1'b0;
		{wr_en, rd_en, trap_req, slow} = 4'h0;
		{addr, ext_en} = 6'h00;
		wr_data = 8'h00;
		{ext_pin, ext_pin_sel} = 48'h0000_0000_0000;
		{periph_flag, periph_clr} = 20'h0_0000;
		periph_en = 10'h3ff;
		cpu_cmd = '0;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset();
		t_regs();
		t_sw();
		t_hw();
		t_trap();
		t_ext();
		t_halt();
		t_wait();
		tally_and_finish();
	end
endmodule

// ---- verilog/npic_arb.sv ----
// Priority picker: highest rank first, then lowest source number.
// Assumes requests and ranks come from logic on the same clock.
`timescale 1ns/1ps

module npic_arb #(
	parameter int N_SRC = 13,
	parameter int IDX_W = 4
) (
	input wire logic [N_SRC-1:0] req,      // Requests competing
	input wire logic [2*N_SRC-1:0] rank,   // Two-bit rank per source
	output logic any,                      // Some request present
	output logic [IDX_W-1:0] idx,          // Winning source number
	output logic [1:0] lvl                 // Winner's rank
);

	// Refuse sizes the index cannot cover
	generate
		if (N_SRC < 1 || (1 << IDX_W) < N_SRC) begin : g_bad
			$error("npic_arb: index too narrow for source count");
		end
	endgenerate

	// Scan from lowest hardware rank up; ties go to the lower number
	always_comb begin
		any = 1'b0;
		idx = '0;
		lvl = 2'h0;
		for (int i = N_SRC - 1; i >= 0; i--) begin
			// Equal rank replaces: lower number ranks higher in hardware
			if (req[i] && (!any || rank[2*i +: 2] >= lvl)) begin
				any = 1'b1;
				idx = IDX_W'(i);
				lvl = rank[2*i +: 2];
			end
		end
	end

endmodule

// ---- verilog/npic_cfg.svh ----
// Constants of the nested priority interrupt controller.
// Assumes inclusion by bare name from the package and the design files.
`ifndef NPIC_CFG_SVH
`define NPIC_CFG_SVH

// Register offsets on the plain register port
`define NPIC_OFF_VP0 3'h0
`define NPIC_OFF_VP1 3'h1
`define NPIC_OFF_VP2 3'h2
`define NPIC_OFF_VP3 3'h3
`define NPIC_OFF_CCP 3'h4
`define NPIC_OFF_PEND_LO 3'h5
`define NPIC_OFF_PEND_HI 3'h6
`define NPIC_OFF_STAT 3'h7

// Reset value of every vector priority register
`define NPIC_VP_RESET 8'hff
// Read-only ones above the single field of the fourth register
`define NPIC_VP3_FIXED 6'h3f

// Current-priority bit positions in the condition code image
`define NPIC_CC_HI_BIT 5
`define NPIC_CC_LO_BIT 3

// Two-bit level codes (high bit, low bit)
`define NPIC_CODE_L0 2'h2
`define NPIC_CODE_L1 2'h1
`define NPIC_CODE_L2 2'h0
`define NPIC_CODE_L3 2'h3

// Sources able to end Halt: 0, 2, 3, 4 and 10
`define NPIC_HALT_WAKE 13'h041d

// Vector codes for the two non-maskable entries
`define NPIC_VEC_TRAP 4'hd
`define NPIC_VEC_RESET 4'he

`endif

// ---- verilog/npic_pkg.sv ----
// Types shared by the interrupt controller files.
// Assumes the constants header sits beside it.
`include "npic_cfg.svh"

package npic_pkg;

	// Level-changing instructions reported by the core
	typedef enum logic [2:0] {
		NPIC_OP_ENABLE,
		NPIC_OP_DISABLE,
		NPIC_OP_HALT,
		NPIC_OP_WAIT,
		NPIC_OP_RETURN,
		NPIC_OP_POP
	} npic_op_t;

	// One instruction report from the core
	typedef struct packed {
		logic valid;      // One-cycle report strobe
		npic_op_t op;     // Which instruction
		logic [1:0] code; // Restored level code for return and pop
	} npic_cmd_t;

	// Service entry towards the core
	typedef struct packed {
		logic valid;       // One-cycle entry strobe
		logic [3:0] vector; // 0..12 maskable, 13 trap, 14 reset
		logic stack;       // Context must be stacked first
	} npic_svc_t;

	// Processor power state as seen by the controller
	typedef enum logic [1:0] {
		NPIC_RUN,
		NPIC_WAITING,
		NPIC_HALTED
	} npic_mode_t;

	// Level code to rank: 10->0, 01->1, 00->2, 11->3
	function automatic logic [1:0] npic_rank(input logic [1:0] code);
		logic [1:0] r;
		r = 2'h0;
		unique case (code)
			`NPIC_CODE_L0: r = 2'h0;
			`NPIC_CODE_L1: r = 2'h1;
			`NPIC_CODE_L2: r = 2'h2;
			`NPIC_CODE_L3: r = 2'h3;
		endcase
		return r;
	endfunction

endpackage

// ---- verilog/npic_top.sv ----
// Nested priority interrupt controller for the 8-bit core.
// Assumes the core reports instruction ends and level-changing opcodes,
// and peripherals present flag, enable and clear-sequence pulses.
`timescale 1ns/1ps
`include "npic_cfg.svh"

module npic_top #(
	parameter int PIN_W = 8,                    // Pins per external line
	parameter logic [12:0] HALT_WAKE = `NPIC_HALT_WAKE // Halt-capable sources
) (
	input wire logic clk_sys,                    // System clock, 50 MHz
	input wire logic reset_n,                    // Asynchronous reset
	input wire logic [2:0] addr,                 // Register address
	input wire logic [7:0] wr_data,              // Register write data
	input wire logic wr_en,                      // Write strobe
	input wire logic rd_en,                      // Read strobe
	output logic [7:0] rd_data,                  // Read data, next cycle
	input wire logic [3*PIN_W-1:0] ext_pin,      // External pins, three lines
	input wire logic [3*PIN_W-1:0] ext_pin_sel,  // Pins chosen per line
	input wire logic [2:0] ext_en,               // External line enables
	input wire logic [9:0] periph_flag,          // Peripheral status flags
	input wire logic [9:0] periph_en,            // Peripheral enable bits
	input wire logic [9:0] periph_clr,           // Clear-sequence pulses
	input wire logic trap_req,                   // Trap instruction pulse
	input wire logic instr_done,                 // Current instruction ends
	input wire npic_pkg::npic_cmd_t cpu_cmd,     // Level-changing opcode
	output npic_pkg::npic_svc_t svc,             // Service entry
	output logic cur_level_hi,                   // Current level high bit
	output logic cur_level_lo,                   // Current level low bit
	output logic wake                            // Wake pulse to core
);

	localparam int N_SRC = 13; // Maskable vectors

	// Refuse pin groups the logic cannot serve
	generate
		if (PIN_W < 1) begin : g_bad_pins
			$error("npic_top: PIN_W must be at least one");
		end
	endgenerate

	// Vector priority registers and their next values
	logic [7:0] vp_reg [4];
	logic [7:0] vp_next [4];
	// Current level code and service bookkeeping
	logic [1:0] cur_code_reg;
	logic [1:0] cur_code_next;
	logic [N_SRC-1:0] pend_reg;
	logic [N_SRC-1:0] pend_next;
	logic trap_pend_reg;
	logic reset_pend_reg;
	logic halt_exit_reg;
	npic_pkg::npic_mode_t mode_reg;
	npic_pkg::npic_mode_t mode_next;
	// Output flops
	npic_pkg::npic_svc_t svc_reg;
	npic_pkg::npic_svc_t svc_next;
	logic wake_reg;
	logic [7:0] rd_data_reg;
	// Pin synchroniser and edge memory
	logic [3*PIN_W-1:0] pin_meta_reg;
	logic [3*PIN_W-1:0] pin_sync_reg;
	logic [2:0] line_prev_reg;

	// External lines: OR of selected, synchronised pins
	wire [2:0] line_level;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_line
			assign line_level[g] = |(pin_sync_reg[g*PIN_W +: PIN_W] &
				ext_pin_sel[g*PIN_W +: PIN_W]);
		end
	endgenerate
	// Rising edge on each line
	wire [2:0] line_edge = line_level & ~line_prev_reg;

	// Source map: 0,1 peripheral, 2..4 external, 5..12 peripheral
	wire [N_SRC-1:0] src_en = {periph_en[9:2], ext_en, periph_en[1:0]};
	// request only with flag and enable
	wire [9:0] periph_req = periph_flag & periph_en;
	wire [N_SRC-1:0] src_set = {periph_req[9:2], line_edge, periph_req[1:0]};
	wire [N_SRC-1:0] src_clr_seq = {periph_clr[9:2], 3'h0, periph_clr[1:0]};
	wire [N_SRC-1:0] src_is_ext = 13'h001c;

	// one field per vector, vector 0 in the low field of the first
	wire [2*N_SRC-1:0] field_code = {vp_reg[3][1:0], vp_reg[2], vp_reg[1],
		vp_reg[0]};
	logic [2*N_SRC-1:0] field_rank;
	always_comb begin
		field_rank = '0;
		for (int i = 0; i < N_SRC; i++) begin
			// code 00 sits at rank two
			field_rank[2*i +: 2] = npic_pkg::npic_rank(field_code[2*i +: 2]);
		end
	end

	wire [N_SRC-1:0] elig = pend_reg & src_en;
	// leaving Halt, only wake-capable requests compete first
	wire [N_SRC-1:0] arb_req = halt_exit_reg ? (elig & HALT_WAKE) : elig;

	wire win_any;
	wire [3:0] win_idx;
	wire [1:0] win_rank;
	npic_arb #(
		.N_SRC(N_SRC),
		.IDX_W(4)
	) u_arb (
		.req(arb_req),
		.rank(field_rank),
		.any(win_any),
		.idx(win_idx),
		.lvl(win_rank)
	);

	// Rank of the level now in force
	wire [1:0] cur_rank = npic_pkg::npic_rank(cur_code_reg);
	// a raised own field with request still pending re-enters
	wire mask_go = win_any && (win_rank > cur_rank);
	// reset, then trap, ahead of maskables
	wire nmi_go = reset_pend_reg || trap_pend_reg;
	// entry only at an instruction end while running
	wire take = instr_done && (mode_reg == npic_pkg::NPIC_RUN) &&
		(nmi_go || mask_go);
	wire take_reset = take && reset_pend_reg;
	wire take_trap = take && !reset_pend_reg && trap_pend_reg;
	wire take_mask = take && !nmi_go;
	// Code of the vector being entered
	wire [1:0] win_code = field_code[2*win_idx +: 2];
	wire [N_SRC-1:0] win_onehot = N_SRC'(1) << win_idx;

	// Pending latches
	always_comb begin
		pend_next = pend_reg;
		// edge requests cleared on their own entry
		if (take_mask) begin
			pend_next = pend_next & ~(win_onehot & src_is_ext);
		end
		pend_next = pend_next & ~src_clr_seq;
		// New events win over any clear in the same cycle
		pend_next = pend_next | src_set;
	end

	// Current level bits
	always_comb begin
		cur_code_next = cur_code_reg;
		if (take_mask) begin
			cur_code_next = win_code;
		end else if (take) begin
			cur_code_next = `NPIC_CODE_L3;
		end else if (cpu_cmd.valid) begin
			unique case (cpu_cmd.op)
				npic_pkg::NPIC_OP_ENABLE: cur_code_next = `NPIC_CODE_L0;
				npic_pkg::NPIC_OP_DISABLE: cur_code_next = `NPIC_CODE_L3;
				npic_pkg::NPIC_OP_HALT: cur_code_next = `NPIC_CODE_L0;
				npic_pkg::NPIC_OP_WAIT: cur_code_next = `NPIC_CODE_L0;
				npic_pkg::NPIC_OP_RETURN: cur_code_next = cpu_cmd.code;
				npic_pkg::NPIC_OP_POP: cur_code_next = cpu_cmd.code;
				default: cur_code_next = cur_code_reg;
			endcase
		end
	end

	// Wake conditions per mode
	// any enabled request ends Wait, only capable ones end Halt
	// trap also ends Halt, reset does not
	wire wake_from_wait = (|elig) || trap_pend_reg;
	wire wake_from_halt = (|(elig & HALT_WAKE)) || trap_pend_reg;

	// Power mode tracking
	always_comb begin
		mode_next = mode_reg;
		unique case (mode_reg)
			npic_pkg::NPIC_RUN: begin
				// Entered by the core's halt and wait opcodes
				if (cpu_cmd.valid && cpu_cmd.op == npic_pkg::NPIC_OP_HALT) begin
					mode_next = npic_pkg::NPIC_HALTED;
				end else if (cpu_cmd.valid && cpu_cmd.op == npic_pkg::NPIC_OP_WAIT) begin
					mode_next = npic_pkg::NPIC_WAITING;
				end
			end
			npic_pkg::NPIC_WAITING: begin
				if (wake_from_wait) begin
					mode_next = npic_pkg::NPIC_RUN;
				end
			end
			npic_pkg::NPIC_HALTED: begin
				if (wake_from_halt) begin
					mode_next = npic_pkg::NPIC_RUN;
				end
			end
			default: mode_next = npic_pkg::NPIC_RUN;
		endcase
	end
	wire waking = (mode_reg != npic_pkg::NPIC_RUN) &&
		(mode_next == npic_pkg::NPIC_RUN);

	// Service entry record
	always_comb begin
		svc_next.valid = take;
		svc_next.stack = take && !take_reset;
		if (take_reset) begin
			svc_next.vector = `NPIC_VEC_RESET;
		end else if (take_trap) begin
			svc_next.vector = `NPIC_VEC_TRAP;
		end else begin
			svc_next.vector = win_idx;
		end
	end

	// Register write decode
	wire wr_vp0 = wr_en && (addr == `NPIC_OFF_VP0);
	wire wr_vp1 = wr_en && (addr == `NPIC_OFF_VP1);
	wire wr_vp2 = wr_en && (addr == `NPIC_OFF_VP2);
	wire wr_vp3 = wr_en && (addr == `NPIC_OFF_VP3);
	wire [3:0] wr_vp = {wr_vp3, wr_vp2, wr_vp1, wr_vp0};

	// Merge a write field by field
	function automatic logic [7:0] vp_merge(input logic [7:0] old_v,
		input logic [7:0] new_v);
		logic [7:0] r;
		r = new_v;
		for (int f = 0; f < 4; f++) begin
			// level-0 code keeps the old field
			if (new_v[2*f +: 2] == `NPIC_CODE_L0) begin
				r[2*f +: 2] = old_v[2*f +: 2];
			end
		end
		return r;
	endfunction

	// Next values of the priority registers
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			vp_next[k] = wr_vp[k] ? vp_merge(vp_reg[k], wr_data) : vp_reg[k];
		end
		// top bits of the fourth register stay ones
		vp_next[3][7:2] = `NPIC_VP3_FIXED;
	end

	// Read images
	wire [7:0] ccp_image = (8'(cur_code_reg[1]) << `NPIC_CC_HI_BIT) |
		(8'(cur_code_reg[0]) << `NPIC_CC_LO_BIT);
	wire [7:0] stat_image = {4'h0, halt_exit_reg, trap_pend_reg, mode_reg};
	logic [7:0] rd_mux;
	always_comb begin
		unique case (addr)
			`NPIC_OFF_VP0: rd_mux = vp_reg[0];
			`NPIC_OFF_VP1: rd_mux = vp_reg[1];
			`NPIC_OFF_VP2: rd_mux = vp_reg[2];
			`NPIC_OFF_VP3: rd_mux = vp_reg[3];
			`NPIC_OFF_CCP: rd_mux = ccp_image;
			`NPIC_OFF_PEND_LO: rd_mux = pend_reg[7:0];
			`NPIC_OFF_PEND_HI: rd_mux = {3'h0, pend_reg[12:8]};
			`NPIC_OFF_STAT: rd_mux = stat_image;
		endcase
	end

	// Two-flop pin synchroniser and line edge memory
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			line_prev_reg <= 3'h0;
		end else begin
			pin_meta_reg <= ext_pin;
			pin_sync_reg <= pin_meta_reg;
			line_prev_reg <= line_level;
		end
	end

	// Priority registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int k = 0; k < 4; k++) begin
				vp_reg[k] <= `NPIC_VP_RESET;
			end
		end else begin
			for (int k = 0; k < 4; k++) begin
				vp_reg[k] <= vp_next[k];
			end
		end
	end

	// Level, pending and mode state
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cur_code_reg <= `NPIC_CODE_L3;
			pend_reg <= '0;
			mode_reg <= npic_pkg::NPIC_RUN;
		end else begin
			cur_code_reg <= cur_code_next;
			pend_reg <= pend_next;
			mode_reg <= mode_next;
		end
	end

	// Non-maskable latches and Halt exit marker
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reset_pend_reg <= 1'b1;
			trap_pend_reg <= 1'b0;
			halt_exit_reg <= 1'b0;
		end else begin
			reset_pend_reg <= reset_pend_reg && !take_reset;
			// New trap wins over its own clear
			trap_pend_reg <= trap_req || (trap_pend_reg && !take_trap);
			// marker drops at first entry, then normal order resumes
			if (take) begin
				halt_exit_reg <= 1'b0;
			end else if (waking && mode_reg == npic_pkg::NPIC_HALTED) begin
				halt_exit_reg <= 1'b1;
			end
		end
	end

	// Output flops
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			svc_reg <= '0;
			wake_reg <= 1'b0;
			rd_data_reg <= 8'h00;
		end else begin
			svc_reg <= svc_next;
			wake_reg <= waking;
			rd_data_reg <= rd_en ? rd_mux : 8'h00;
		end
	end

	// Ports from flops
	assign svc = svc_reg;
	assign wake = wake_reg;
	assign rd_data = rd_data_reg;
	assign cur_level_hi = cur_code_reg[1];
	assign cur_level_lo = cur_code_reg[0];

endmodule
